/* File: design/sac_ctrl.sv */
// attenuator control port top: mode select, latching and active word
`timescale 1ns/1ps
module sac_ctrl
	import sac_pkg::*;
(
	input  wire logic                  mclk,
	input  wire logic                  resetn,
	input  wire logic                  serial_clk,
	input  wire logic                  serial_data,
	input  wire logic                  latch_strobe,
	input  wire logic                  interface_select,
	input  wire logic [SAC_WEIGHT_W-1:0] weight_pins,
	output logic [SAC_WEIGHT_W-1:0]    atten_q,
	output logic [SAC_WORD_W-1:0]      active_word_q,
	output logic [1:0]                 mode_q
);
	logic [1:0]                rst_sync_q;
	logic                      rst_n;
	logic [1:0]                sel_sync_q;
	logic [1:0]                le_sync_q;
	logic                      le_prev_q;
	logic [SAC_WEIGHT_W-1:0]   pin_s1_q;
	logic [SAC_WEIGHT_W-1:0]   pin_s2_q;
	logic [SAC_WORD_W-1:0]     shift_word;
	logic [SAC_WORD_W-1:0]     word_s1_q;
	logic [SAC_WORD_W-1:0]     word_s2_q;
	logic                      sel_serial;
	logic                      le_s;
	logic                      le_rise;
	sac_mode_t                 mode;
	logic [SAC_WORD_W-1:0]     active_d;
	logic [SAC_WORD_W-1:0]     par_word;

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			rst_sync_q <= 2'h0;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_q[1];

	// the link-side register is async reset by the raw pin reset, like power-up
	sac_shift_link u_link (
		.sclk        (serial_clk),
		.rst_n       (resetn),
		.serial_data (serial_data),
		.latch_strobe(latch_strobe),
		.serial_sel  (interface_select),
		.shift_q     (shift_word)
	);

	// shift word is stable while strobe high, so a plain two-stage capture is safe
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			sel_sync_q <= 2'h3;
			// reset to the strobe's idle level, so no false rise follows reset
			le_sync_q  <= 2'h3;
			le_prev_q  <= 1'b1;
			pin_s1_q   <= SAC_MAX_ATTEN;
			pin_s2_q   <= SAC_MAX_ATTEN;
			word_s1_q  <= SAC_RESET_WORD;
			word_s2_q  <= SAC_RESET_WORD;
		end else begin
			sel_sync_q <= {sel_sync_q[0], interface_select};
			le_sync_q  <= {le_sync_q[0], latch_strobe};
			le_prev_q  <= le_sync_q[1];
			pin_s1_q   <= weight_pins;
			pin_s2_q   <= pin_s1_q;
			word_s1_q  <= shift_word;
			word_s2_q  <= word_s1_q;
		end
	end

	assign sel_serial = sel_sync_q[1];
	assign le_s       = le_sync_q[1];
	assign le_rise    = le_s & ~le_prev_q;
	assign mode       = sel_serial ? SAC_MODE_SERIAL :
	                    (le_s ? SAC_MODE_DIRECT : SAC_MODE_LATCHED);
	// reserved top bit always stored as zero on the parallel path
	assign par_word   = {1'b0, pin_s2_q};

	always_comb begin
		active_d = active_word_q;
		case (mode)
			SAC_MODE_SERIAL: begin
				if (le_rise) begin
					active_d = word_s2_q;
				end
			end
			SAC_MODE_DIRECT: begin
				active_d = par_word;
			end
			SAC_MODE_LATCHED: begin
				active_d = active_word_q;
			end
			default: begin
				active_d = active_word_q;
			end
		endcase
		// strobe rising with select low lands in direct mode on this same cycle
		if (!sel_serial && le_rise) begin
			active_d = par_word;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			active_word_q <= SAC_RESET_WORD;
			atten_q       <= SAC_MAX_ATTEN;
			mode_q        <= 2'h0;
		end else begin
			active_word_q <= active_d;
			// each set bit steps in its binary weight in quarter dB units
			atten_q       <= active_d[SAC_WEIGHT_W-1:0];
			mode_q        <= mode;
		end
	end

	property p_latch_serial;
		@(posedge mclk) disable iff (!rst_n)
		(mode == SAC_MODE_SERIAL && le_rise) |=> active_word_q == $past(word_s2_q);
	endproperty
	a_latch_serial: assert property (p_latch_serial)
		else $error("serial word not latched on strobe rise");
	property p_direct;
		@(posedge mclk) disable iff (!rst_n)
		(mode == SAC_MODE_DIRECT) |=> active_word_q == {1'b0, $past(pin_s2_q)};
	endproperty
	a_direct: assert property (p_direct)
		else $error("direct mode did not follow pins");
	property p_latched_hold;
		@(posedge mclk) disable iff (!rst_n)
		(mode == SAC_MODE_LATCHED && !le_rise) |=> $stable(active_word_q);
	endproperty
	a_latched_hold: assert property (p_latched_hold)
		else $error("latched mode reacted to pins");
	property p_serial_hold;
		@(posedge mclk) disable iff (!rst_n)
		(mode == SAC_MODE_SERIAL && !le_rise) |=> $stable(active_word_q);
	endproperty
	a_serial_hold: assert property (p_serial_hold)
		else $error("serial active word changed without strobe");
	property p_weights;
		@(posedge mclk) disable iff (!rst_n)
		atten_q == active_word_q[SAC_WEIGHT_W-1:0];
	endproperty
	a_weights: assert property (p_weights)
		else $error("attenuation output differs from active word");
	property p_rsv;
		@(posedge mclk) disable iff (!rst_n)
		(mode != SAC_MODE_SERIAL) |=> active_word_q[SAC_RSV_POS] == 1'b0;
	endproperty
	a_rsv: assert property (p_rsv)
		else $error("reserved bit set on parallel path");
	property p_mode;
		@(posedge mclk) disable iff (!rst_n)
		sel_serial |=> mode_q == 2'(SAC_MODE_SERIAL);
	endproperty
	a_mode: assert property (p_mode)
		else $error("select high did not give serial mode");
	property p_reset_max;
		@(posedge mclk)
		$rose(rst_n) |-> active_word_q == SAC_RESET_WORD;
	endproperty
	a_reset_max: assert property (p_reset_max)
		else $error("not at maximum attenuation after reset");

	// a strobe rise with select low adopts the pins on that same cycle
	property p_latch_par;
		@(posedge mclk) disable iff (!rst_n)
		(!sel_serial && le_rise) |=> active_word_q == {1'b0, $past(pin_s2_q)};
	endproperty
	a_latch_par: assert property (p_latch_par)
		else $error("parallel pins not adopted on strobe rise");

	property p_mode_direct;
		@(posedge mclk) disable iff (!rst_n)
		(!sel_serial && le_s) |=> mode_q == 2'(SAC_MODE_DIRECT);
	endproperty
	a_mode_direct: assert property (p_mode_direct)
		else $error("select low with strobe high did not give direct mode");

	property p_mode_latched;
		@(posedge mclk) disable iff (!rst_n)
		(!sel_serial && !le_s) |=> mode_q == 2'(SAC_MODE_LATCHED);
	endproperty
	a_mode_latched: assert property (p_mode_latched)
		else $error("select low with strobe low did not give latched mode");

	property p_mode_legal;
		@(posedge mclk) disable iff (!rst_n)
		mode_q != 2'h3;
	endproperty
	a_mode_legal: assert property (p_mode_legal)
		else $error("mode output holds an unused code");

	property p_atten_reset;
		@(posedge mclk)
		$rose(rst_n) |-> atten_q == SAC_MAX_ATTEN;
	endproperty
	a_atten_reset: assert property (p_atten_reset)
		else $error("attenuation output not at maximum after reset");

	// a false rise here would reload a stale shift word after reset
	property p_no_rise_at_reset;
		@(posedge mclk)
		$rose(rst_n) |-> !le_rise;
	endproperty
	a_no_rise_at_reset: assert property (p_no_rise_at_reset)
		else $error("strobe edge detector fired on reset release");

	property p_rise_single;
		@(posedge mclk) disable iff (!rst_n)
		le_rise |=> !le_rise;
	endproperty
	a_rise_single: assert property (p_rise_single)
		else $error("strobe rise lasted more than one cycle");

	// the captured shift word must have settled before it is latched
	property p_word_settled;
		@(posedge mclk) disable iff (!rst_n)
		(sel_serial && le_rise) |-> word_s1_q == word_s2_q;
	endproperty
	a_word_settled: assert property (p_word_settled)
		else $error("shift word still moving at latch time");

	property p_direct_atten;
		@(posedge mclk) disable iff (!rst_n)
		(mode == SAC_MODE_DIRECT) |=> atten_q == $past(pin_s2_q);
	endproperty
	a_direct_atten: assert property (p_direct_atten)
		else $error("direct mode attenuation did not follow pins");

	property p_serial_atten_hold;
		@(posedge mclk) disable iff (!rst_n)
		(sel_serial && !le_rise) |=> $stable(atten_q);
	endproperty
	a_serial_atten_hold: assert property (p_serial_atten_hold)
		else $error("serial mode attenuation reacted to pins");

	property p_latched_atten_hold;
		@(posedge mclk) disable iff (!rst_n)
		(mode == SAC_MODE_LATCHED) |=> $stable(atten_q);
	endproperty
	a_latched_atten_hold: assert property (p_latched_atten_hold)
		else $error("latched mode attenuation moved with strobe low");

	property p_rsv_atten;
		@(posedge mclk) disable iff (!rst_n)
		(mode != SAC_MODE_SERIAL) |=> active_word_q[SAC_WEIGHT_W-1:0] == atten_q;
	endproperty
	a_rsv_atten: assert property (p_rsv_atten)
		else $error("parallel attenuation differs from active word");
	c_serial_latch: cover property (@(posedge mclk) disable iff (!rst_n)
		mode == SAC_MODE_SERIAL && le_rise);
	c_direct: cover property (@(posedge mclk) disable iff (!rst_n)
		mode == SAC_MODE_DIRECT ##1 $changed(active_word_q));
	c_latched: cover property (@(posedge mclk) disable iff (!rst_n)
		mode == SAC_MODE_LATCHED ##[1:20] le_rise);
endmodule

/* File: design/sac_pkg.sv */
// constants and types for the step attenuator control port
package sac_pkg;
	localparam int          SAC_WORD_W       = 8;
	localparam int          SAC_WEIGHT_W     = 7;
	localparam int          SAC_RSV_POS      = 7;
	localparam logic [7:0]  SAC_RESET_WORD   = 8'h007f;
	localparam logic [6:0]  SAC_MAX_ATTEN    = 7'h007f;
	localparam int          SAC_QDB_PER_LSB  = 1;
	localparam int          SAC_CLK_NS       = 40;
	localparam int          SAC_MODE_SETUP_NS = 100;
	localparam int          SAC_MODE_SETUP_CYC = (SAC_MODE_SETUP_NS + SAC_CLK_NS - 1) / SAC_CLK_NS;
	typedef enum logic [1:0] {
		SAC_MODE_SERIAL,
		SAC_MODE_DIRECT,
		SAC_MODE_LATCHED
	} sac_mode_t;
endpackage

/* File: design/sac_shift_link.sv */
// serial shift register running on the serial clock
`timescale 1ns/1ps
module sac_shift_link
	import sac_pkg::*;
(
	input  wire logic                  sclk,
	input  wire logic                  rst_n,
	input  wire logic                  serial_data,
	input  wire logic                  latch_strobe,
	input  wire logic                  serial_sel,
	output logic [SAC_WORD_W-1:0]      shift_q
);
	logic shift_en;
	// gating by strobe keeps bus noise out when idle
	assign shift_en = serial_sel & ~latch_strobe;
	always_ff @(posedge sclk or negedge rst_n) begin
		if (!rst_n) begin
			shift_q <= SAC_RESET_WORD;
		end else if (shift_en) begin
			// new bit enters at top, so first bit ends at bit zero
			shift_q <= {serial_data, shift_q[SAC_WORD_W-1:1]};
		end
	end
	// looks back one edge, since the clock stands still between frames
	property p_hold_when_strobe;
		@(posedge sclk) disable iff (!rst_n)
		$past(latch_strobe) |-> $stable(shift_q);
	endproperty
	a_hold_when_strobe: assert property (p_hold_when_strobe)
		else $error("shift register moved with strobe high");
	property p_shift_in;
		@(posedge sclk) disable iff (!rst_n)
		shift_en |=> shift_q[SAC_WORD_W-1] == $past(serial_data);
	endproperty
	a_shift_in: assert property (p_shift_in)
		else $error("serial bit not shifted in");
	property p_shift_lsb;
		@(posedge sclk) disable iff (!rst_n)
		shift_en |=> shift_q[SAC_WORD_W-2:0] == $past(shift_q[SAC_WORD_W-1:1]);
	endproperty
	a_shift_lsb: assert property (p_shift_lsb)
		else $error("shift direction wrong");
	c_shift: cover property (@(posedge sclk) disable iff (!rst_n) shift_en [*8]);
endmodule

/* File: testbench/sac_host_model.sv */
// host controller model driving the serial and parallel control pins
`timescale 1ns/1ps
module sac_host_model
	import sac_pkg::*;
(
	output logic                    serial_clk,
	output logic                    serial_data,
	output logic                    latch_strobe,
	output logic                    interface_select,
	output logic [SAC_WEIGHT_W-1:0] weight_pins
);
	initial begin
		serial_clk = 1'b0;
		serial_data = 1'b0;
		latch_strobe = 1'b1;
		interface_select = 1'b1;
		weight_pins = '0;
	end
	// clock stands still outside frames; data is inverted once its hold has run out
	task automatic shift(input logic [7:0] w, input logic strobe_lo);
		if (strobe_lo) latch_strobe <= 1'b0;
		#12;
		for (int i = 0; i < 8; i++) begin
			serial_data <= w[i];
			#6 serial_clk <= 1'b1;
			#6 serial_clk <= 1'b0;
		end
		#6 serial_data <= ~w[7];
		#6;
	endtask
	task automatic strobe(input logic v);
		latch_strobe <= v;
		#120;
	endtask
	task automatic select(input logic v);
		interface_select <= v;
		#200;
	endtask
	task automatic pins(input logic [6:0] v);
		weight_pins <= v;
		#40;
	endtask
endmodule

/* File: testbench/tb_top.sv */
// self-checking bench for the attenuator control port
`timescale 1ns/1ps
module tb_top;
	import sac_pkg::*;
	logic                    mclk = 1'b0;
	logic                    resetn;
	logic                    serial_clk, serial_data, latch_strobe, interface_select;
	logic [SAC_WEIGHT_W-1:0] weight_pins, atten_q, p;
	logic [SAC_WORD_W-1:0]   active_word_q, w;
	logic [1:0]              mode_q;
	int                      num_errors = 0;
	int                      n_compared = 0;
	int                      cycles = 0;
	always #20 mclk = ~mclk;
	sac_host_model host (.serial_clk(serial_clk), .serial_data(serial_data),
		.latch_strobe(latch_strobe), .interface_select(interface_select),
		.weight_pins(weight_pins));
	sac_ctrl dut (.mclk(mclk), .resetn(resetn), .serial_clk(serial_clk),
		.serial_data(serial_data), .latch_strobe(latch_strobe),
		.interface_select(interface_select), .weight_pins(weight_pins),
		.atten_q(atten_q), .active_word_q(active_word_q), .mode_q(mode_q));
	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_compared++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	// parallel words carry a zero reserved bit
	function automatic logic [7:0] par_word(input logic [6:0] v);
		return {1'b0, v};
	endfunction
	task automatic expect_state(input logic [7:0] wd, input logic [1:0] m);
		repeat (6) @(posedge mclk);
		@(negedge mclk);
		check("active_word_q", wd, active_word_q);
		check("atten_q", {1'b0, wd[6:0]}, {1'b0, atten_q});
		check("mode_q", {6'h00, m}, {6'h00, mode_q});
	endtask
	task automatic wrap_up();
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	// ceiling well above the few hundred cycles the sequence needs
	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			num_errors++;
			wrap_up();
		end
	end
	initial begin
		resetn <= 1'b0;
		void'($urandom(75));
		repeat (16) @(posedge mclk);
		resetn <= 1'b1;
		repeat (4) @(posedge mclk);
		expect_state(SAC_RESET_WORD, SAC_MODE_SERIAL);
		for (int i = 0; i < 6; i++) begin
			w = (i == 0) ? 8'h0080 : (i == 1) ? 8'h0001 : 8'($urandom);
			host.shift(w, 1'b1);
			host.strobe(1'b1);
			expect_state(w, SAC_MODE_SERIAL);
		end
		// clocks while strobe is high must leave the shift word alone
		host.shift(~w, 1'b0);
		host.strobe(1'b0);
		host.strobe(1'b1);
		expect_state(w, SAC_MODE_SERIAL);
		host.select(1'b0);
		for (int i = 0; i < 5; i++) begin
			p = (i == 0) ? 7'h00 : 7'($urandom);
			host.pins(p);
			expect_state(par_word(p), SAC_MODE_DIRECT);
		end
		host.strobe(1'b0);
		host.pins(~p);
		expect_state(par_word(p), SAC_MODE_LATCHED);
		host.strobe(1'b1);
		expect_state(par_word(~p), SAC_MODE_DIRECT);
		host.strobe(1'b0);
		@(posedge mclk);
		resetn <= 1'b0;
		repeat (4) @(posedge mclk);
		resetn <= 1'b1;
		repeat (4) @(posedge mclk);
		expect_state(SAC_RESET_WORD, SAC_MODE_LATCHED);
		host.pins(7'h0055);
		host.strobe(1'b1);
		expect_state(par_word(7'h0055), SAC_MODE_DIRECT);
		host.select(1'b1);
		expect_state(par_word(7'h0055), SAC_MODE_SERIAL);
		wrap_up();
	end
endmodule
